/* rtl/rcs_pkg.sv */
// Purpose: Constants and types for the sample clock select block
// Assumes: AXI4-Lite register access, one 50 MHz clock
// Notes:   Register index times four gives the byte address
// How it works
// (R1) Ext select bit picks pin clock
// (R2) L count field 27:16, resets 256
// (R3) M count field 15:4, resets 1563
// (R4) Fractional select takes fractional divider output
// (R5) Bypass bit skips ref divider, resets 0
// (R6) Bit 0 selects sample interface mode
// (R7) Software keeps reserved bits when writing
// (R8) Ref divider scales rate by L/M
package rcs_pkg;
    // ************************************************
    // Register map
    // ************************************************
    localparam logic [7:0]  CFG_IDX     = 8'h07;
    localparam logic [7:0]  TEST_IDX    = 8'h08;
    localparam logic [7:0]  CFG_ADDR    = 8'(CFG_IDX * 4);
    localparam logic [7:0]  TEST_ADDR   = 8'(TEST_IDX * 4);
    localparam logic [11:0] RST_L       = 12'h100;
    localparam logic [11:0] RST_M       = 12'h61B;
    localparam logic [31:0] RST_TEST    = 32'h01E0F401;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
    // Fractional divider ratio, numerator over denominator
    localparam logic [11:0] FRAC_NUM    = 12'h001;
    localparam logic [11:0] FRAC_DEN    = 12'h002;

    // ************************************************
    // Types
    // ************************************************
    typedef struct packed {
        logic [2:0]  rsvd_hi;
        logic        external_sample_clock_select;
        logic [11:0] ref_divider_l_count;
        logic [11:0] ref_divider_m_count;
        logic        fractional_divider_select;
        logic        sample_clock_bypass_select;
        logic        rsvd_b1;
        logic        dsp_mode_select;
    } rcs_cfg_t;

    localparam rcs_cfg_t RST_CFG = '{3'h0, 1'b0, RST_L, RST_M,
                                     1'b0, 1'b0, 1'b1, 1'b0};

    typedef struct packed {
        logic        en;
        logic [7:0]  addr;
        logic [31:0] data;
        logic [3:0]  strb;
    } rcs_wreq_t;

    typedef enum logic [1:0] {
        SEL_NONE = 2'b00,
        SEL_CFG  = 2'b01,
        SEL_TEST = 2'b10
    } rcs_sel_t;

    // Address decode shared by write and read paths
    function automatic rcs_sel_t rcs_decode(input logic [7:0] a);
        if (a == CFG_ADDR) begin
            return SEL_CFG;
        end else if (a == TEST_ADDR) begin
            return SEL_TEST;
        end
        return SEL_NONE;
    endfunction

    // Byte-lane merge of a write into a stored word
    function automatic logic [31:0] rcs_merge(input logic [31:0] o,
                                              input logic [31:0] n,
                                              input logic [3:0]  s);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[i*8 +: 8] = n[i*8 +: 8];
            end
        end
        return r;
    endfunction
endpackage

/* rtl/rcs_ratio_gen.sv */
// Purpose: Rate scaler, one tick per den/num advances
// Assumes: num not above den for a true division
// Notes:   den of zero gives a tick on every advance
`timescale 1ns/1ps
module rcs_ratio_gen
    import rcs_pkg::*;
(
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // Rate setting
    input  wire logic        adv,
    input  wire logic [11:0] num,
    input  wire logic [11:0] den,
    // Output
    output logic             tick_r
);
    logic [12:0] acc_r;
    logic [12:0] acc_nxt;
    logic [12:0] sum;
    logic        tick_nxt;

    // Accumulate num, wrap at den; wrap marks a tick
    always_comb begin
        sum      = acc_r + {1'b0, num};
        acc_nxt  = acc_r;
        tick_nxt = 1'b0;
        if (adv) begin
            if (den == 12'h000) begin
                acc_nxt  = 13'h0000;
                tick_nxt = 1'b1;
            end else if (sum >= {1'b0, den}) begin
                // A lowered den leaves acc above it; restart, no burst
                acc_nxt  = (acc_r >= {1'b0, den}) ? 13'h0000
                                                   : sum - {1'b0, den};  // R8
                tick_nxt = 1'b1;
            end else begin
                acc_nxt  = sum;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            acc_r  <= 13'h0000;
            tick_r <= 1'b0;
        end else begin
            acc_r  <= acc_nxt;
            tick_r <= tick_nxt;
        end
    end
endmodule

/* rtl/rcs_axil_slave.sv */
// Purpose: AXI4-Lite slave front end, one write and one read at a time
// Assumes: Master holds valid and payload until ready
// Notes:   Unmapped addresses answer SLVERR, read data zero
`timescale 1ns/1ps
module rcs_axil_slave
    import rcs_pkg::*;
(
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // Write channels
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // Read channels
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // Register side
    output rcs_wreq_t        wreq,
    output logic [7:0]       rd_addr,
    input  wire logic [31:0] rd_data
);
    logic        aw_full_r, aw_full_nxt, w_full_r, w_full_nxt;
    logic        ar_full_r, ar_full_nxt;
    logic        awready_nxt, wready_nxt, arready_nxt;
    logic        bvalid_nxt, rvalid_nxt;
    logic [1:0]  bresp_nxt, rresp_nxt;
    logic [7:0]  waddr_r, waddr_nxt, raddr_r, raddr_nxt;
    logic [31:0] wdata_r, wdata_nxt, rdata_nxt;
    logic [3:0]  wstrb_r, wstrb_nxt;
    logic        do_wr, wr_hit, rd_hit;

    assign do_wr   = aw_full_r && w_full_r && !bvalid;
    assign wr_hit  = rcs_decode(waddr_r) != SEL_NONE;
    assign rd_hit  = rcs_decode(raddr_r) != SEL_NONE;
    assign wreq    = '{do_wr && wr_hit, waddr_r, wdata_r, wstrb_r};
    assign rd_addr = raddr_r;

    // Channel bookkeeping; address and data may come in either order
    always_comb begin
        aw_full_nxt = aw_full_r;
        w_full_nxt  = w_full_r;
        ar_full_nxt = ar_full_r;
        waddr_nxt   = waddr_r;
        wdata_nxt   = wdata_r;
        wstrb_nxt   = wstrb_r;
        raddr_nxt   = raddr_r;
        bvalid_nxt  = bvalid;
        bresp_nxt   = bresp;
        rvalid_nxt  = rvalid;
        rresp_nxt   = rresp;
        rdata_nxt   = rdata;
        if (awvalid && awready) begin
            aw_full_nxt = 1'b1;
            waddr_nxt   = awaddr;
        end
        if (wvalid && wready) begin
            w_full_nxt = 1'b1;
            wdata_nxt  = wdata;
            wstrb_nxt  = wstrb;
        end
        if (bvalid && bready) begin
            bvalid_nxt = 1'b0;
        end
        if (do_wr) begin
            aw_full_nxt = 1'b0;
            w_full_nxt  = 1'b0;
            bvalid_nxt  = 1'b1;
            bresp_nxt   = wr_hit ? RESP_OKAY : RESP_SLVERR;
        end
        if (arvalid && arready) begin
            ar_full_nxt = 1'b1;
            raddr_nxt   = araddr;
        end
        if (rvalid && rready) begin
            rvalid_nxt = 1'b0;
        end
        if (ar_full_r && !rvalid) begin
            ar_full_nxt = 1'b0;
            rvalid_nxt  = 1'b1;
            rdata_nxt   = rd_data;
            rresp_nxt   = rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        // Ready only with room; holds off a second transfer
        awready_nxt = !aw_full_nxt && !bvalid_nxt;
        wready_nxt  = !w_full_nxt && !bvalid_nxt;
        arready_nxt = !ar_full_nxt && !rvalid_nxt;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_r <= 1'b0;
            w_full_r  <= 1'b0;
            ar_full_r <= 1'b0;
            waddr_r   <= 8'h00;
            wdata_r   <= 32'h00000000;
            wstrb_r   <= 4'h0;
            raddr_r   <= 8'h00;
            awready   <= 1'b0;
            wready    <= 1'b0;
            arready   <= 1'b0;
            bvalid    <= 1'b0;
            bresp     <= RESP_OKAY;
            rvalid    <= 1'b0;
            rresp     <= RESP_OKAY;
            rdata     <= 32'h00000000;
        end else begin
            aw_full_r <= aw_full_nxt;
            w_full_r  <= w_full_nxt;
            ar_full_r <= ar_full_nxt;
            waddr_r   <= waddr_nxt;
            wdata_r   <= wdata_nxt;
            wstrb_r   <= wstrb_nxt;
            raddr_r   <= raddr_nxt;
            awready   <= awready_nxt;
            wready    <= wready_nxt;
            arready   <= arready_nxt;
            bvalid    <= bvalid_nxt;
            bresp     <= bresp_nxt;
            rvalid    <= rvalid_nxt;
            rresp     <= rresp_nxt;
            rdata     <= rdata_nxt;
        end
    end
endmodule

/* rtl/rcs_clock_select.sv */
// Purpose: Clock configuration registers and sample clock selection
// Assumes: External sample clock pin is synchronous to aclk
// Notes:   Sample clock is given as a one-cycle enable tick on aclk
`timescale 1ns/1ps
module rcs_clock_select
    import rcs_pkg::*;
(
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write
    input  wire logic [7:0]  s_axil_awaddr,
    input  wire logic        s_axil_awvalid,
    output logic             s_axil_awready,
    input  wire logic [31:0] s_axil_wdata,
    input  wire logic [3:0]  s_axil_wstrb,
    input  wire logic        s_axil_wvalid,
    output logic             s_axil_wready,
    output logic [1:0]       s_axil_bresp,
    output logic             s_axil_bvalid,
    input  wire logic        s_axil_bready,
    // AXI4-Lite read
    input  wire logic [7:0]  s_axil_araddr,
    input  wire logic        s_axil_arvalid,
    output logic             s_axil_arready,
    output logic [31:0]      s_axil_rdata,
    output logic [1:0]       s_axil_rresp,
    output logic             s_axil_rvalid,
    input  wire logic        s_axil_rready,
    // Clock pins and settings out
    input  wire logic        external_sample_clock_pin,
    output rcs_cfg_t         clock_cfg_r,
    output logic             sample_tick_r
);
    // ************************************************
    // Bus front end
    // ************************************************
    rcs_wreq_t   wreq;
    logic [7:0]  rd_addr;
    logic [31:0] rd_data;
    logic [31:0] test_r, test_nxt;
    rcs_cfg_t    cfg_nxt;

    rcs_axil_slave u_slave (
        .aclk    (aclk),
        .aresetn (aresetn),
        .awaddr  (s_axil_awaddr),
        .awvalid (s_axil_awvalid),
        .awready (s_axil_awready),
        .wdata   (s_axil_wdata),
        .wstrb   (s_axil_wstrb),
        .wvalid  (s_axil_wvalid),
        .wready  (s_axil_wready),
        .bresp   (s_axil_bresp),
        .bvalid  (s_axil_bvalid),
        .bready  (s_axil_bready),
        .araddr  (s_axil_araddr),
        .arvalid (s_axil_arvalid),
        .arready (s_axil_arready),
        .rdata   (s_axil_rdata),
        .rresp   (s_axil_rresp),
        .rvalid  (s_axil_rvalid),
        .rready  (s_axil_rready),
        .wreq    (wreq),
        .rd_addr (rd_addr),
        .rd_data (rd_data)
    );

    // ************************************************
    // Registers
    // ************************************************
    // Reserved bits are stored as written, so read-modify-write keeps them
    always_comb begin
        cfg_nxt  = clock_cfg_r;
        test_nxt = test_r;
        if (wreq.en && rcs_decode(wreq.addr) == SEL_CFG) begin
            cfg_nxt = rcs_cfg_t'(rcs_merge(clock_cfg_r, wreq.data,
                                           wreq.strb));  // R7
        end
        if (wreq.en && rcs_decode(wreq.addr) == SEL_TEST) begin
            test_nxt = rcs_merge(test_r, wreq.data, wreq.strb);  // R7
        end
    end

    // Read mux; unmapped reads return zero
    always_comb begin
        case (rcs_decode(rd_addr))
            SEL_CFG:  rd_data = clock_cfg_r;  // R2 R3
            SEL_TEST: rd_data = test_r;
            default:  rd_data = 32'h00000000;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clock_cfg_r <= RST_CFG;  // R2 R3 R5 R6
            test_r      <= RST_TEST;
        end else begin
            clock_cfg_r <= cfg_nxt;
            test_r      <= test_nxt;
        end
    end

    // ************************************************
    // Sample clock path
    // ************************************************
    logic ref_tick, frac_tick, path_tick, int_tick;
    logic ext_d_r, ext_d_nxt, ext_edge, sample_nxt;

    // Reference divider/multiplier, rate scaled by L over M
    rcs_ratio_gen u_ref_div (
        .aclk    (aclk),
        .aresetn (aresetn),
        .adv     (1'b1),
        .num     (clock_cfg_r.ref_divider_l_count),  // R8
        .den     (clock_cfg_r.ref_divider_m_count),
        .tick_r  (ref_tick)
    );

    // Fractional divider fed from the selected reference path
    rcs_ratio_gen u_frac_div (
        .aclk    (aclk),
        .aresetn (aresetn),
        .adv     (path_tick),
        .num     (FRAC_NUM),
        .den     (FRAC_DEN),
        .tick_r  (frac_tick)
    );

    // Bypass and fractional selection, then internal or pin source
    always_comb begin
        path_tick = clock_cfg_r.sample_clock_bypass_select ?
                    1'b1 : ref_tick;  // R5
        int_tick  = clock_cfg_r.fractional_divider_select ?
                    frac_tick : path_tick;  // R4
        ext_d_nxt = external_sample_clock_pin;
        ext_edge  = external_sample_clock_pin && !ext_d_r;
        sample_nxt = clock_cfg_r.external_sample_clock_select ?
                     ext_edge : int_tick;  // R1
    end

    // Edge detect on the pin costs one cycle of latency
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_d_r       <= 1'b0;
            sample_tick_r <= 1'b0;
        end else begin
            ext_d_r       <= ext_d_nxt;
            sample_tick_r <= sample_nxt;
        end
    end

    // ************************************************
    // Assertions
    // ************************************************
    logic cfg_sel;
    assign cfg_sel = clock_cfg_r.external_sample_clock_select;

    a_ext_pin_edge: assert property (  // R1
        @(posedge aclk) disable iff (!aresetn)
        (cfg_sel && external_sample_clock_pin && !ext_d_r) |=> sample_tick_r)
        else $error("pin edge not passed to sample tick");

    a_l_reset_val: assert property (  // R2
        @(posedge aclk) !aresetn |=>
        clock_cfg_r.ref_divider_l_count == RST_L)
        else $error("L count reset value wrong");

    a_m_reset_val: assert property (  // R3
        @(posedge aclk) !aresetn |=>
        clock_cfg_r.ref_divider_m_count == RST_M)
        else $error("M count reset value wrong");

    a_frac_gate: assert property (  // R4
        @(posedge aclk) disable iff (!aresetn)
        (!cfg_sel && clock_cfg_r.fractional_divider_select && !frac_tick)
        |=> !sample_tick_r)
        else $error("tick without fractional divider output");

    a_bypass_every: assert property (  // R5
        @(posedge aclk) disable iff (!aresetn)
        (!cfg_sel && !clock_cfg_r.fractional_divider_select &&
         clock_cfg_r.sample_clock_bypass_select) |=> sample_tick_r)
        else $error("bypass did not pass reference clock");

    a_mode_write: assert property (  // R6
        @(posedge aclk) disable iff (!aresetn)
        (wreq.en && wreq.addr == CFG_ADDR && wreq.strb[0])
        |=> clock_cfg_r.dsp_mode_select == $past(wreq.data[0]))
        else $error("interface mode bit not written");

    a_ref_ratio: assert property (  // R8
        @(posedge aclk) disable iff (!aresetn)
        (clock_cfg_r.ref_divider_l_count == 12'h001 &&
         clock_cfg_r.ref_divider_m_count == 12'h002 && ref_tick
         && $stable(clock_cfg_r)) |=> !ref_tick)
        else $error("ratio one half gave back to back ticks");

    c_ext_used: cover property (@(posedge aclk) cfg_sel && sample_tick_r);
    c_frac_used: cover property (@(posedge aclk)
        clock_cfg_r.fractional_divider_select && sample_tick_r);
    c_cfg_write: cover property (@(posedge aclk)
        wreq.en && wreq.addr == CFG_ADDR);
endmodule

/* verification/tb_ref_clock_adc_clock_select.sv */
// Purpose: Self-checking bench for the clock select register block
// Assumes: AXI4-Lite slave, one 50 MHz clock, pin synchronous to aclk
// Notes:   Internal sample rates are judged as tick counts over a window
`timescale 1ns/1ps
module tb_ref_clock_adc_clock_select;
    import rcs_pkg::*;
    localparam logic [31:0] RSV_MASK = 32'hE0000002;
    localparam int          WIN      = 240;
    logic        aclk, aresetn, pin, p1, p2, ext_chk;
    logic [7:0]  awaddr, araddr;
    logic        awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, tick;
    logic [31:0] wdata, rdata, wd;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    rcs_cfg_t    cfg;
    logic [31:0] mdl [int];
    int          num_errors, total_checks, cycles, n, e;
    logic [7:0]  addrs [5] = '{CFG_ADDR, TEST_ADDR, 8'h1D, 8'h24, 8'h00};
    int          lv [6] = '{0, 0, 1, 1, 3, 1};
    int          mv [6] = '{0, 0, 4, 4, 8, 2};
    int          fv [6] = '{0, 1, 0, 1, 0, 0};
    int          bv [6] = '{1, 1, 0, 0, 0, 0};

    rcs_clock_select dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axil_awaddr(awaddr), .s_axil_awvalid(awvalid),
        .s_axil_awready(awready), .s_axil_wdata(wdata),
        .s_axil_wstrb(wstrb), .s_axil_wvalid(wvalid),
        .s_axil_wready(wready), .s_axil_bresp(bresp),
        .s_axil_bvalid(bvalid), .s_axil_bready(bready),
        .s_axil_araddr(araddr), .s_axil_arvalid(arvalid),
        .s_axil_arready(arready), .s_axil_rdata(rdata),
        .s_axil_rresp(rresp), .s_axil_rvalid(rvalid),
        .s_axil_rready(rready), .external_sample_clock_pin(pin),
        .clock_cfg_r(cfg), .sample_tick_r(tick));

    // ************************************************
    // Clock, timeout and pin stimulus
    // ************************************************
    initial aclk = 1'b0;
    always #10 aclk = ~aclk;

    // Pin history kept so a rising edge can be predicted two cycles on
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        p2 <= p1;
        p1 <= pin;
        pin <= 1'($urandom);
        if (ext_chk) chk("sample_tick_r", 32'(p1 & ~p2), 32'(tick));
        if (cycles == 40000) begin
            num_errors++;
            complete_run();
        end
    end

    // ************************************************
    // Tasks
    // ************************************************
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Reset also returns the model to the documented defaults
    task automatic do_reset();
        aresetn <= 1'b0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        mdl[CFG_ADDR] = 32'h010061B2;
        mdl[TEST_ADDR] = RST_TEST;
        @(posedge aclk);
        chk("reset clock_cfg_r", mdl[CFG_ADDR], cfg);
    endtask

    // Address and data offered together, each dropped once taken
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                             input logic [3:0] s, output logic [1:0] r);
        bit pa, pw;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        pa = 1'b1;
        pw = 1'b1;
        while (pa || pw) begin
            @(posedge aclk);
            if (pa && awready === 1'b1) begin
                awvalid <= 1'b0;
                pa = 1'b0;
            end
            if (pw && wready === 1'b1) begin
                wvalid <= 1'b0;
                pw = 1'b0;
            end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                            output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    // Model merges enabled byte lanes; unmapped places hold nothing
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d,
                             input logic [3:0] s);
        logic [1:0] r;
        axi_write(a, d, s, r);
        chk("bresp", mdl.exists(a) ? RESP_OKAY : RESP_SLVERR, r);
        if (mdl.exists(a)) begin
            for (int i = 0; i < 4; i++) begin
                if (s[i]) mdl[a][i*8 +: 8] = d[i*8 +: 8];
            end
        end
    endtask

    task automatic reg_read(input logic [7:0] a);
        logic [31:0] d;
        logic [1:0]  r;
        axi_read(a, d, r);
        chk("rresp", mdl.exists(a) ? RESP_OKAY : RESP_SLVERR, r);
        chk("rdata", mdl.exists(a) ? mdl[a] : 32'h0, d);
    endtask

    // Software side keeps every reserved bit as it was
    task automatic set_cfg(input logic [31:0] v);
        v = (v & ~RSV_MASK) | (mdl[CFG_ADDR] & RSV_MASK);
        reg_write(CFG_ADDR, v, 4'hF);
        @(posedge aclk);
        chk("clock_cfg_r", mdl[CFG_ADDR], cfg);
    endtask

    task automatic count_ticks(output int cnt);
        cnt = 0;
        repeat (8) @(posedge aclk);
        repeat (WIN) begin
            @(posedge aclk);
            cnt += (tick === 1'b1) ? 1 : 0;
        end
    endtask

    // ************************************************
    // Main sequence
    // ************************************************
    initial begin
        void'($urandom(32'h2b7a089f));
        {awvalid, wvalid, bready, arvalid, rready, pin, ext_chk} = '0;
        {p1, p2} = '0;
        {awaddr, araddr, wdata, wstrb} = '0;
        {num_errors, total_checks, cycles} = '0;
        aresetn = 1'b0;
        do_reset();
        reg_read(CFG_ADDR);
        reg_read(TEST_ADDR);
        $display("test reset_values done");

        // Strobed traffic, mapped and unmapped, test word left as it was
        for (int i = 0; i < 15; i++) begin
            e = $urandom_range(4, 0);
            if (addrs[e] == CFG_ADDR) begin
                wd = ($urandom() & ~RSV_MASK) | (mdl[CFG_ADDR] & RSV_MASK);
            end else if (addrs[e] == TEST_ADDR) begin
                wd = mdl[TEST_ADDR];
            end else begin
                wd = $urandom();
            end
            reg_write(addrs[e], wd, 4'($urandom_range(15, 1)));
            reg_read(addrs[e]);
        end
        $display("test register_access done");

        // Internal paths: bypass, fractional halving, L over M scaling
        for (int i = 0; i < 6; i++) begin
            set_cfg({3'h0, 1'b0, 12'(lv[i]), 12'(mv[i]), 1'(fv[i]),
                     1'(bv[i]), 1'b0, 1'($urandom)});
            count_ticks(n);
            e = (bv[i] != 0) ? WIN : WIN * lv[i] / mv[i];
            if (fv[i] != 0) e = e / 2;
            total_checks++;
            if (n < e - 2 || n > e + 2) begin
                num_errors++;
                $display("mismatch tick_count expected %0d seen %0d", e, n);
            end
        end
        $display("test internal_paths done");

        // Rising edges on the external pin drive the sample tick, one cycle later
        set_cfg({3'h0, 1'b1, 12'h001, 12'h004, 1'b1, 1'b0, 1'b0,
                 1'b1});
        repeat (3) @(posedge aclk);
        ext_chk <= 1'b1;
        repeat (120) @(posedge aclk);
        ext_chk <= 1'b0;
        $display("test external_pin done");

        // Second reset in mid-run restores defaults
        do_reset();
        reg_read(CFG_ADDR);
        $display("test second_reset done");
        complete_run();
    end
endmodule
